// ### verilog/timer8_compare_waveform_modes.v
/*
 8-bit timer/counter with normal, clear-on-match and fast pwm modes,
 overflow and compare flags, forced compare, and a compare output pin,
 all reached over a classic wishbone slave.
 assumes a single 200 MHz clock, asynchronous active-low reset, and
 interrupt service acknowledges arriving as pulses on the same clock.
*/
// Implementation choices: the Wishbone slave port and the register offsets.
// How it works
// - mode field picks action and pin source
// - nonzero mode field overrides port output value
// - port direction bit still controls pin driver
// - mode zero leaves compare output unchanged
// - new mode acts at next match; force
// - counting depends only on waveform mode
// - normal mode counts up, wraps after max
// - normal overflow flag set when counter wraps
// - counter writable any time in normal mode
// - clear-on-match clears counter at compare value
// - clear-on-match uses compare value unbuffered
// - clear-on-match raises compare flag at top
// - clear-on-match toggle mode toggles output
// - clear-on-match overflow set at max wrap
// - fast pwm counts to max, then clears
// - fast pwm non-inverting and inverting actions
// - fast pwm overflow set at max
// - fast pwm extreme compare values handled
// - fast pwm toggle mode, still double buffered
// - period 256 ticks; prescale 1 to 1024
// - match sets compare flag; write-one clears
// - pwm compare writes buffered until top
// - clock select zero stops; writes override counting
// - force updates output only, no flag
`timescale 1ns/10ps
`include "timer8_consts.vh"

module timer8_compare_waveform_modes (
	input wire CLOCK,
	input wire RSTN,
	input wire WB_CYC_I,
	input wire WB_STB_I,
	input wire WB_WE_I,
	input wire [7:0] WB_ADR_I,
	input wire [3:0] WB_SEL_I,
	input wire [31:0] WB_DAT_I,
	output reg [31:0] WB_DAT_O,
	output reg WB_ACK_O,
	input wire OVERFLOW_SERVICED,
	input wire COMPARE_SERVICED,
	output reg OVERFLOW_FLAG,
	output reg COMPARE_FLAG,
	output wire COMPARE_PIN_OUT,
	output wire COMPARE_PIN_OE_N
);

	// control state
	reg [1:0] waveform_mode_ff; // counting sequence select
	reg [1:0] compare_output_mode_ff; // output action select
	reg [2:0] clock_select_ff; // prescaler select, zero stops
	reg compare_interrupt_enable_ff; // stored for software only
	reg compare_pin_direction_bit_ff; // one drives the pin
	reg port_value_ff; // normal port output value

	// counting state
	reg [7:0] counter_value_ff; // the counter
	reg [7:0] compare_value_ff; // active compare register
	reg [7:0] compare_buffer_ff; // software side in pwm modes
	reg [9:0] prescale_ff; // prescaler count
	reg block_ff; // match blocked after a counter write

	// next values
	reg [7:0] nxt_counter_value;
	reg [7:0] nxt_compare_value;
	reg [7:0] nxt_compare_buffer;
	reg [9:0] nxt_prescale;
	reg nxt_block;
	reg nxt_overflow_flag;
	reg nxt_compare_flag;
	reg [31:0] nxt_rdata;

	// decoded signals
	reg [9:0] divisor; // prescaler terminal count
	wire timer_clock_enable; // one tick of the timer clock
	wire pwm_mode; // buffered compare, single slope
	wire at_max; // counter is at max
	wire at_compare; // counter equals active compare
	wire match_evt; // compare match taken this tick
	wire bottom_evt; // counter cleared from max to bottom
	wire top_clear; // clear-on-match reset of the counter
	wire force_evt; // forced compare from a control write
	wire compare_output; // internal compare output state

	// bus decode
	wire req; // live request before the answer
	wire wr_take; // write takes effect on the ack edge
	wire wr_ctrl;
	wire wr_cnt;
	wire wr_cmp;
	wire wr_flags;
	wire wr_pin;

	// both pwm codes use single-slope counting here
	assign pwm_mode = waveform_mode_ff[0];
	assign at_max = (counter_value_ff == `CNT_MAX);
	assign at_compare = (counter_value_ff == compare_value_ff);

	// request is answered one cycle later; writes land with the ack
	assign req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
	assign wr_take = WB_CYC_I & WB_STB_I & WB_ACK_O & WB_WE_I & WB_SEL_I[0];
	assign wr_ctrl = wr_take & (WB_ADR_I == `ADDR_CONTROL);
	assign wr_cnt = wr_take & (WB_ADR_I == `ADDR_COUNTER);
	assign wr_cmp = wr_take & (WB_ADR_I == `ADDR_COMPARE);
	assign wr_flags = wr_take & (WB_ADR_I == `ADDR_FLAGS);
	assign wr_pin = wr_take & (WB_ADR_I == `ADDR_PIN);

	// prescaler divisor by clock select code
	always @* begin
		case (clock_select_ff)
			3'h1: divisor = `DIV_1;
			3'h2: divisor = `DIV_8;
			3'h3: divisor = `DIV_32;
			3'h4: divisor = `DIV_64;
			3'h5: divisor = `DIV_128;
			3'h6: divisor = `DIV_256;
			3'h7: divisor = `DIV_1024;
			default: divisor = `DIV_1;
		endcase
	end

	// tick when prescaler hits its count; select zero stops the timer
	assign timer_clock_enable = (clock_select_ff != 3'h0) &&
		(prescale_ff >= divisor);

	// prescaler count
	always @* begin
		if (clock_select_ff == 3'h0 || timer_clock_enable) begin
			nxt_prescale = 10'h000;
		end else begin
			nxt_prescale = prescale_ff + 10'h001;
		end
	end

	// a match on a tick, unless a counter write blocked it
	assign match_evt = timer_clock_enable & at_compare & ~block_ff;
	// clear-on-match clears the counter on compare equality
	assign top_clear = (waveform_mode_ff == `WAVE_CLEAR_ON_MATCH) & at_compare;
	// fast pwm bottom: the tick where max rolls to zero
	assign bottom_evt = timer_clock_enable & pwm_mode & at_max;
	// force only acts outside pwm modes
	assign force_evt = wr_ctrl & WB_DAT_I[`CTRL_FORCE_BIT] & ~pwm_mode;

	// counter next value, by waveform mode only
	always @* begin
		nxt_counter_value = counter_value_ff;
		if (wr_cnt) begin
			// software write beats count and clear
			nxt_counter_value = WB_DAT_I[7:0];
		end else if (timer_clock_enable) begin
			case (waveform_mode_ff)
				`WAVE_NORMAL: begin
					// plain up count with wrap through max
					nxt_counter_value = counter_value_ff + 8'h01;
				end
				`WAVE_CLEAR_ON_MATCH: begin
					// below-count compare only matches after the wrap
					if (top_clear) begin
						nxt_counter_value = `CNT_BOTTOM;
					end else begin
						nxt_counter_value = counter_value_ff + 8'h01;
					end
				end
				default: begin
					// single slope: max, then bottom on the next tick
					if (at_max) begin
						nxt_counter_value = `CNT_BOTTOM;
					end else begin
						nxt_counter_value = counter_value_ff + 8'h01;
					end
				end
			endcase
		end
	end

	// a counter write blocks the match on the next tick
	always @* begin
		nxt_block = block_ff;
		if (wr_cnt) begin
			nxt_block = 1'b1;
		end else if (timer_clock_enable) begin
			nxt_block = 1'b0;
		end
	end

	// compare register and its buffer
	always @* begin
		nxt_compare_value = compare_value_ff;
		nxt_compare_buffer = compare_buffer_ff;
		if (wr_cmp) begin
			nxt_compare_buffer = WB_DAT_I[7:0];
		end
		if (!pwm_mode) begin
			// non-pwm: software reaches the active register directly
			if (wr_cmp) begin
				nxt_compare_value = WB_DAT_I[7:0];
			end
		end else if (bottom_evt) begin
			// pwm: copy buffer at top, so pulses stay whole
			nxt_compare_value = compare_buffer_ff;
		end
	end

	// overflow flag: set on the max-to-zero tick, set beats clear
	always @* begin
		nxt_overflow_flag = OVERFLOW_FLAG;
		if (wr_flags && WB_DAT_I[`FLAG_OVF_BIT]) begin
			nxt_overflow_flag = 1'b0;
		end
		if (OVERFLOW_SERVICED) begin
			nxt_overflow_flag = 1'b0;
		end
		if (timer_clock_enable && at_max && !wr_cnt) begin
			// all four mode codes flag at max rolling to zero
			nxt_overflow_flag = 1'b1;
		end
	end

	// compare flag: set by a real match only, never by force
	always @* begin
		nxt_compare_flag = COMPARE_FLAG;
		if (wr_flags && WB_DAT_I[`FLAG_CMP_BIT]) begin
			nxt_compare_flag = 1'b0;
		end
		if (COMPARE_SERVICED) begin
			nxt_compare_flag = 1'b0;
		end
		if (match_evt) begin
			nxt_compare_flag = 1'b1;
		end
	end

	// read data mux; force bit always reads zero
	always @* begin
		nxt_rdata = 32'h00000000;
		case (WB_ADR_I)
			`ADDR_CONTROL: begin
				nxt_rdata[`CTRL_WAVE0_BIT] = waveform_mode_ff[0];
				nxt_rdata[`CTRL_COM_HI:`CTRL_COM_LO] = compare_output_mode_ff;
				nxt_rdata[`CTRL_WAVE1_BIT] = waveform_mode_ff[1];
				nxt_rdata[`CTRL_CS_HI:`CTRL_CS_LO] = clock_select_ff;
			end
			`ADDR_COUNTER: nxt_rdata[7:0] = counter_value_ff;
			`ADDR_COMPARE: nxt_rdata[7:0] = pwm_mode ? compare_buffer_ff : compare_value_ff;
			`ADDR_FLAGS: begin
				nxt_rdata[`FLAG_OVF_BIT] = OVERFLOW_FLAG;
				nxt_rdata[`FLAG_CMP_BIT] = COMPARE_FLAG;
				nxt_rdata[`FLAG_IE_BIT] = compare_interrupt_enable_ff;
			end
			`ADDR_PIN: begin
				nxt_rdata[`PIN_DIR_BIT] = compare_pin_direction_bit_ff;
				nxt_rdata[`PIN_PORT_BIT] = port_value_ff;
				nxt_rdata[`PIN_STATE_BIT] = compare_output;
			end
			default: nxt_rdata = 32'h00000000; // unmapped reads zero
		endcase
	end

	// bus answer: ack one cycle after the request, for one cycle
	always @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h00000000;
		end else begin
			WB_ACK_O <= req;
			if (req) begin
				WB_DAT_O <= nxt_rdata;
			end
		end
	end

	// software-written control registers
	always @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			waveform_mode_ff <= `WAVE_NORMAL;
			compare_output_mode_ff <= `COM_OFF;
			clock_select_ff <= 3'h0;
			compare_interrupt_enable_ff <= 1'b0;
			compare_pin_direction_bit_ff <= 1'b0;
			port_value_ff <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				waveform_mode_ff <= {WB_DAT_I[`CTRL_WAVE1_BIT], WB_DAT_I[`CTRL_WAVE0_BIT]};
				compare_output_mode_ff <= WB_DAT_I[`CTRL_COM_HI:`CTRL_COM_LO];
				clock_select_ff <= WB_DAT_I[`CTRL_CS_HI:`CTRL_CS_LO];
			end
			if (wr_flags) begin
				compare_interrupt_enable_ff <= WB_DAT_I[`FLAG_IE_BIT];
			end
			if (wr_pin) begin
				compare_pin_direction_bit_ff <= WB_DAT_I[`PIN_DIR_BIT];
				port_value_ff <= WB_DAT_I[`PIN_PORT_BIT];
			end
		end
	end

	// counting state and flags
	always @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			counter_value_ff <= `RST_BYTE;
			compare_value_ff <= `RST_BYTE;
			compare_buffer_ff <= `RST_BYTE;
			prescale_ff <= 10'h000;
			block_ff <= 1'b0;
			OVERFLOW_FLAG <= 1'b0;
			COMPARE_FLAG <= 1'b0;
		end else begin
			counter_value_ff <= nxt_counter_value;
			compare_value_ff <= nxt_compare_value;
			compare_buffer_ff <= nxt_compare_buffer;
			prescale_ff <= nxt_prescale;
			block_ff <= nxt_block;
			OVERFLOW_FLAG <= nxt_overflow_flag;
			COMPARE_FLAG <= nxt_compare_flag;
		end
	end

	// compare output state and pin drive; the new mode field acts at
	// the next match since the unit reads it live
	compare_output_unit u_output (
		.clock(CLOCK),
		.rstn(RSTN),
		.match_evt(match_evt),
		.bottom_evt(bottom_evt),
		.force_evt(force_evt),
		.pwm_mode(pwm_mode),
		.compare_output_mode(wr_ctrl ? WB_DAT_I[`CTRL_COM_HI:`CTRL_COM_LO] :
			compare_output_mode_ff),
		.compare_pin_direction_bit(compare_pin_direction_bit_ff),
		.port_value(port_value_ff),
		.compare_output_ff(compare_output),
		.pin_out_ff(COMPARE_PIN_OUT),
		.pin_oe_n_ff(COMPARE_PIN_OE_N)
	);

endmodule // timer8_compare_waveform_modes

// ### verilog/timer8_consts.vh
/*
 constants for the 8-bit timer with compare output and waveform modes:
 register byte addresses, field positions, reset values, mode codes, divisors.
 assumes inclusion by bare name from the timer design files.
*/
`ifndef TIMER8_CONSTS_VH
`define TIMER8_CONSTS_VH

// register byte addresses on the wishbone slave
`define ADDR_CONTROL 8'h00
`define ADDR_COUNTER 8'h04
`define ADDR_COMPARE 8'h08
`define ADDR_FLAGS 8'h0C
`define ADDR_PIN 8'h10

// control register fields
`define CTRL_FORCE_BIT 7
`define CTRL_WAVE0_BIT 6
`define CTRL_COM_HI 5
`define CTRL_COM_LO 4
`define CTRL_WAVE1_BIT 3
`define CTRL_CS_HI 2
`define CTRL_CS_LO 0

// flag register fields
`define FLAG_OVF_BIT 0
`define FLAG_CMP_BIT 1
`define FLAG_IE_BIT 8

// pin control register fields
`define PIN_DIR_BIT 0
`define PIN_PORT_BIT 1
`define PIN_STATE_BIT 2

// waveform mode codes
`define WAVE_NORMAL 2'h0
`define WAVE_PHASE 2'h1
`define WAVE_CLEAR_ON_MATCH 2'h2
`define WAVE_FAST 2'h3

// compare output mode codes
`define COM_OFF 2'h0
`define COM_TOGGLE 2'h1
`define COM_CLEAR 2'h2
`define COM_SET 2'h3

// counter extremes
`define CNT_BOTTOM 8'h00
`define CNT_MAX 8'hFF

// reset values
`define RST_BYTE 8'h00

// prescaler divisors minus one, by clock select code
`define DIV_1 10'h000
`define DIV_8 10'h007
`define DIV_32 10'h01F
`define DIV_64 10'h03F
`define DIV_128 10'h07F
`define DIV_256 10'h0FF
`define DIV_1024 10'h3FF

`endif

// ### verilog/compare_output_unit.v
/*
 compare output unit: holds the internal compare output state and drives
 the pin from it or from the port value, with direction from the port bit.
 assumes match, bottom and force events are one-cycle pulses on CLOCK.
*/
`timescale 1ns/10ps
`include "timer8_consts.vh"

module compare_output_unit (
	input wire clock,
	input wire rstn,
	input wire match_evt,
	input wire bottom_evt,
	input wire force_evt,
	input wire pwm_mode,
	input wire [1:0] compare_output_mode,
	input wire compare_pin_direction_bit,
	input wire port_value,
	output reg compare_output_ff,
	output reg pin_out_ff,
	output reg pin_oe_n_ff
);

	reg nxt_compare_output; // next internal compare output state
	wire override; // pin sourced from compare output

	// either mode bit set takes the pin over, in every waveform mode
	assign override = |compare_output_mode;

	// action on the compare output state
	always @* begin
		nxt_compare_output = compare_output_ff;
		if (pwm_mode) begin
			// single slope: bottom wins so a max compare stays constant
			if (bottom_evt && compare_output_mode == `COM_CLEAR) begin
				nxt_compare_output = 1'b1;
			end else if (bottom_evt && compare_output_mode == `COM_SET) begin
				nxt_compare_output = 1'b0;
			end else if (match_evt) begin
				case (compare_output_mode)
					`COM_TOGGLE: nxt_compare_output = ~compare_output_ff;
					`COM_CLEAR: nxt_compare_output = 1'b0;
					`COM_SET: nxt_compare_output = 1'b1;
					default: nxt_compare_output = compare_output_ff;
				endcase
			end
		end else if (match_evt || force_evt) begin
			// non-pwm: toggle, clear or set; force acts like a match
			case (compare_output_mode)
				`COM_TOGGLE: nxt_compare_output = ~compare_output_ff;
				`COM_CLEAR: nxt_compare_output = 1'b0;
				`COM_SET: nxt_compare_output = 1'b1;
				default: nxt_compare_output = compare_output_ff;
			endcase
		end
	end

	// state register and registered pin drive
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			compare_output_ff <= 1'b0;
			pin_out_ff <= 1'b0;
			pin_oe_n_ff <= 1'b1;
		end else begin
			compare_output_ff <= nxt_compare_output;
			pin_out_ff <= override ? nxt_compare_output : port_value;
			// direction stays with the port bit even when overridden
			pin_oe_n_ff <= ~compare_pin_direction_bit;
		end
	end

endmodule // compare_output_unit

// ### dv/timer8_asserts.sv
/*
 port checker for the timer block: bus answer, flag clearing, pin enable.
 assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/10ps
`include "timer8_consts.vh"
module timer8_asserts (
	input wire CLOCK,
	input wire RSTN,
	input wire WB_CYC_I,
	input wire WB_STB_I,
	input wire WB_WE_I,
	input wire [7:0] WB_ADR_I,
	input wire [31:0] WB_DAT_O,
	input wire WB_ACK_O,
	input wire OVERFLOW_SERVICED,
	input wire COMPARE_SERVICED,
	input wire OVERFLOW_FLAG,
	input wire COMPARE_FLAG,
	input wire COMPARE_PIN_OUT,
	input wire COMPARE_PIN_OE_N
);
	// request still waiting for its ack
	wire req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	// write taking effect, read answered
	wire wr = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O;
	wire rd = WB_ACK_O && !WB_WE_I;
	wire flag_wr = wr && WB_ADR_I == `ADDR_FLAGS;
	wire pin_wr = wr && WB_ADR_I == `ADDR_PIN;
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RSTN);
	// ack pulse followed by its drop
	sequence s_answer;
		WB_ACK_O ##1 !WB_ACK_O;
	endsequence
	a_ack_one_cycle: assert property (req |=> s_answer)
		else $error("ack not a one cycle answer");
	a_ack_has_cause: assert property (WB_ACK_O |-> $past(req))
		else $error("ack without request");
	a_unmapped_reads_zero: assert property (rd && WB_ADR_I > `ADDR_PIN |-> WB_DAT_O == 32'h0)
		else $error("unmapped read not zero");
	a_force_reads_zero: assert property (rd && WB_ADR_I == `ADDR_CONTROL |-> WB_DAT_O[31:7] == 25'h0)
		else $error("force strobe read back");
	a_ovf_only_set: assert property ($fell(OVERFLOW_FLAG) |-> $past(flag_wr) || $past(OVERFLOW_SERVICED))
		else $error("overflow flag cleared by itself");
	a_cmp_clear_cause: assert property ($fell(COMPARE_FLAG) |-> $past(flag_wr) || $past(COMPARE_SERVICED))
		else $error("compare flag cleared by itself");
	a_reset_values: assert property ($rose(RSTN) |-> !OVERFLOW_FLAG && !COMPARE_FLAG && COMPARE_PIN_OE_N && !COMPARE_PIN_OUT)
		else $error("bad state after reset");
	a_oe_after_write: assert property ($changed(COMPARE_PIN_OE_N) |-> $past(pin_wr, 2) || $past(pin_wr, 3))
		else $error("pin enable moved without direction write");
	a_data_on_ack: assert property ($changed(WB_DAT_O) |-> WB_ACK_O)
		else $error("read data moved outside an answer");
endmodule // timer8_asserts

bind timer8_compare_waveform_modes timer8_asserts i_timer8_asserts (.CLOCK(CLOCK), .RSTN(RSTN),
	.WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
	.WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .OVERFLOW_SERVICED(OVERFLOW_SERVICED),
	.COMPARE_SERVICED(COMPARE_SERVICED), .OVERFLOW_FLAG(OVERFLOW_FLAG),
	.COMPARE_FLAG(COMPARE_FLAG), .COMPARE_PIN_OUT(COMPARE_PIN_OUT),
	.COMPARE_PIN_OE_N(COMPARE_PIN_OE_N));

// ### dv/pin_model.sv
/*
 port pin model: resolves the pin level from value and enable.
 assumes a pull-up on the pin when nobody drives it.
*/
`timescale 1ns/10ps
module pin_model (
	input wire pin_out,
	input wire pin_oe_n,
	output wire pin_level
);
	// released pin floats to the pull-up level
	assign pin_level = pin_oe_n ? 1'b1 : pin_out;
endmodule // pin_model

// ### dv/tb_top.sv
/*
 testbench for the timer block: wishbone tasks and timed port checks.
 assumes the design, pin model and checker are compiled before it.
*/
`timescale 1ns/10ps
`include "timer8_consts.vh"
module tb_top;
	reg clk = 1'b0; // system clock
	reg rstn = 1'b0; // reset, active low
	reg cyc = 1'b0; // bus request
	reg stb = 1'b0;
	reg we = 1'b0;
	reg [7:0] adr = 8'h00;
	reg [31:0] dat_i = 32'h0;
	reg ovf_srv = 1'b0; // service pulses
	reg cmp_srv = 1'b0;
	wire [31:0] dat_o;
	wire ack, ovf, cmp, pin_out, oe_n, pin_level;
	integer miscompares = 0;
	integer n_tests = 0;
	integer cycles = 0; // timeout counter
	integer i, n, p;
	localparam [9:0] coms = 10'h05B; // force modes 3,2,1,1,0
	localparam [4:0] sts = 5'h05; // state after each force

	always #2.5 clk = ~clk;
	timer8_compare_waveform_modes i_timer8_compare_waveform_modes (.CLOCK(clk), .RSTN(rstn),
		.WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
		.WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .OVERFLOW_SERVICED(ovf_srv),
		.COMPARE_SERVICED(cmp_srv), .OVERFLOW_FLAG(ovf), .COMPARE_FLAG(cmp),
		.COMPARE_PIN_OUT(pin_out), .COMPARE_PIN_OE_N(oe_n));
	pin_model i_pin_model (.pin_out(pin_out), .pin_oe_n(oe_n), .pin_level(pin_level));

	task close_out;
		$display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
		if (miscompares == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares = miscompares + 1;
			close_out;
		end
	end

	task chk(input [31:0] got, input [31:0] exp);
		n_tests = n_tests + 1;
		if (got !== exp) begin
			miscompares = miscompares + 1;
			$display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	// one classic cycle, held until ack, then idle one cycle
	task wb(input w, input [7:0] a, input [31:0] d, output [31:0] q);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat_i <= d;
		do @(posedge clk); while (ack !== 1'b1);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask

	task wr(input [7:0] a, input [31:0] d);
		reg [31:0] q;
		wb(1'b1, a, d, q);
	endtask

	task rd(input [7:0] a, input [31:0] e);
		reg [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask

	function [31:0] ctl(input [1:0] wm, input [1:0] com, input [2:0] cs, input f);
		ctl = {24'h0, f, wm[0], com, wm[1], cs};
	endfunction

	// service the flag, then count edges until it is seen set again
	task gap(input c, output integer m);
		reg seen;
		seen = 1'b0;
		if (c)
			cmp_srv <= 1'b1;
		else
			ovf_srv <= 1'b1;
		@(posedge clk);
		ovf_srv <= 1'b0;
		cmp_srv <= 1'b0;
		m = 1;
		while (!(seen && (c ? cmp : ovf) === 1'b1)) begin
			if ((c ? cmp : ovf) === 1'b0)
				seen = 1'b1;
			@(posedge clk);
			m = m + 1;
		end
	endtask

	// length of one whole pin phase at level lvl
	task high_len(input lvl, output integer m);
		m = 0;
		while (pin_level === lvl) @(posedge clk);
		while (pin_level !== lvl) @(posedge clk);
		while (pin_level === lvl) begin
			@(posedge clk);
			m = m + 1;
		end
	endtask

	task pwm_case(input [1:0] com, input [7:0] c, input lvl, input [31:0] e);
		wr(`ADDR_CONTROL, ctl(`WAVE_FAST, com, 3'h1, 1'b0));
		wr(`ADDR_COMPARE, {24'h0, c});
		high_len(lvl, n);
		chk(n, e);
	endtask

	// main sequence
	initial begin
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk({31'h0, oe_n}, 32'h1);
		for (i = 0; i < 5; i = i + 1)
			rd(8'(i * 4), 32'h0);
		rd(8'h14, 32'h0);
		// forced compare with the timer stopped
		wr(`ADDR_COUNTER, 32'h55);
		wr(`ADDR_PIN, 32'h1);
		for (i = 0; i < 5; i = i + 1) begin
			wr(`ADDR_CONTROL, ctl(`WAVE_NORMAL, coms[2*i +: 2], 3'h0, 1'b1));
			rd(`ADDR_PIN, {29'h0, sts[i], 2'h1});
		end
		rd(`ADDR_FLAGS, 32'h0);
		rd(`ADDR_COUNTER, 32'h55);
		// pin source follows the mode field
		wr(`ADDR_PIN, 32'h3);
		repeat (2) @(posedge clk);
		chk({31'h0, pin_out}, 32'h1);
		wr(`ADDR_CONTROL, ctl(`WAVE_NORMAL, `COM_CLEAR, 3'h0, 1'b0));
		repeat (2) @(posedge clk);
		chk({31'h0, pin_out}, 32'h0);
		wr(`ADDR_PIN, 32'h2);
		repeat (2) @(posedge clk);
		chk({30'h0, oe_n, pin_level}, 32'h3);
		wr(`ADDR_PIN, 32'h1);
		// normal mode: written counter wraps on the third tick
		wr(`ADDR_CONTROL, ctl(`WAVE_NORMAL, `COM_OFF, 3'h1, 1'b0));
		wr(`ADDR_COUNTER, 32'hFD);
		gap(1'b0, n);
		chk(n, 32'h3);
		gap(1'b0, n);
		chk(n, 32'h100);
		// clear-on-match, top 3, toggling pin
		wr(`ADDR_CONTROL, ctl(`WAVE_CLEAR_ON_MATCH, `COM_TOGGLE, 3'h0, 1'b0));
		wr(`ADDR_COMPARE, 32'h3);
		wr(`ADDR_COUNTER, 32'h0);
		wr(`ADDR_CONTROL, ctl(`WAVE_CLEAR_ON_MATCH, `COM_TOGGLE, 3'h1, 1'b0));
		gap(1'b1, n);
		gap(1'b1, n);
		chk(n, 32'h4);
		p = pin_level;
		repeat (4) @(posedge clk);
		chk({31'h0, pin_level ^ p[0]}, 32'h1);
		// fast pwm polarity and extremes
		pwm_case(`COM_CLEAR, 8'h40, 1'b1, 32'h41);
		pwm_case(`COM_CLEAR, 8'h00, 1'b1, 32'h1);
		wr(`ADDR_COMPARE, 32'hFF);
		repeat (300) @(posedge clk);
		p = 0;
		repeat (300) begin
			@(posedge clk);
			if (pin_level !== 1'b1)
				p = p + 1;
		end
		chk(p, 32'h0);
		pwm_case(`COM_SET, 8'h40, 1'b0, 32'h41);
		gap(1'b0, n);
		gap(1'b0, n);
		chk(n, 32'h100);
		// fast pwm toggle: one flip per period
		pwm_case(`COM_TOGGLE, 8'h40, 1'b1, 32'h100);
		// mode 1 also runs single slope; divide by 8 stretches the period
		wr(`ADDR_CONTROL, ctl(`WAVE_PHASE, `COM_OFF, 3'h2, 1'b0));
		gap(1'b0, n);
		gap(1'b0, n);
		chk(n, 32'h800);
		// stopped timer: both flags held, writing ones clears them
		wr(`ADDR_CONTROL, ctl(`WAVE_NORMAL, `COM_OFF, 3'h0, 1'b0));
		rd(`ADDR_FLAGS, 32'h3);
		wr(`ADDR_FLAGS, 32'h103);
		rd(`ADDR_FLAGS, 32'h100);
		close_out;
	end
endmodule // tb_top
